/* core/sbr_ctrl.sv */
// Purpose: Current limit, burst mode and auto-restart sequencing
// Assumes: Comparator decisions arrive asynchronous; 10 MHz clock
// Notes:   Avalon-MM slave; every access answers on its second edge
//
// What this block does
// - Sense above current limit resets the PWM latch in the same cycle.
// - Sense comparators ignored for 400ns (four cycles) after every switch-on.
// - Blanking gates peak limit, burst limit and PWM amplifier paths.
// - Reduced 0.34V limit active only during burst mode.
// - Steeper current ramp selects a lowered threshold, ending pulse earlier.
// - Burst counter held at zero, counts below 1.35V, enters after 20ms.
// - Burst entry sets burst flag and turns bias off.
// - In burst with bias off, feedback above 3.5V restores bias.
// - Bursting, feedback down to 3.0V turns bias off again.
// - Feedback above 4.0V in burst leaves burst, restoring full limit.
// - Startup cell stays off throughout burst mode.
// - After 20ms clamp released; restart waits for pin at 4.0V.
// - Further 30us spike blanking before auto restart.
// - Burst uses fixed blanking; restart allows fixed or extended.
// - Fast faults restart at once; overload/open loop use blanking.
// - Restart stops switching, cell on at turn-off, off at turn-on.
// - After startup phase fault rechecked; restart again or run normal.
// - Feedback above 4.0V in normal operation starts overload count.
// - External restart request ignored for 1ms after startup.
//
// The Avalon-MM slave port and the register offsets were left to the implementer.

`timescale 1ns/100ps

// --------------------
// Two-stage synchroniser
// --------------------
module sbr_sync2 #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         clk_in,
    input  wire logic         nrst_in,
    // Data
    input  wire logic [W-1:0] d_in,
    output logic      [W-1:0] q_out
);
    logic [W-1:0] meta_r;
    logic [W-1:0] hold_r;

    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            meta_r <= '0;
            hold_r <= '0;
        end else begin
            meta_r <= d_in;
            hold_r <= meta_r;
        end
    end

    assign q_out = hold_r;
endmodule

// --------------------
// Controller top
// --------------------
module sbr_ctrl #(
    parameter int BLANK_CYC = sbr_pkg::BLANK_CYC,
    parameter int ARM_CYC   = sbr_pkg::ARM_CYC
) (
    // Clock and reset
    input  wire logic                     clk_in,
    input  wire logic                     nrst_in,
    // Comparator decisions
    input  wire sbr_pkg::sbr_cmp_s        cmp_in,
    // Avalon-MM slave
    input  wire logic [sbr_pkg::ADDR_W-1:0] avs_address_in,
    input  wire logic                     avs_read_in,
    input  wire logic                     avs_write_in,
    input  wire logic [31:0]              avs_writedata_in,
    input  wire logic [3:0]               avs_byteenable_in,
    output logic      [31:0]              avs_readdata_out,
    output logic                          avs_waitrequest_out,
    // Power stage control
    output logic                          pwm_latch_reset_out,
    output logic                          bias_en_out,
    output logic                          startup_cell_en_out,
    output logic                          burst_flag_out,
    output logic                          extend_clamp_out,
    output logic                          auto_restart_out,
    output logic                          soft_start_out
);
    localparam int CW = sbr_pkg::CNT_W;
    localparam int LW = sbr_pkg::LEB_W;

    // --------------------
    // Input synchronisation
    // --------------------
    logic [$bits(sbr_pkg::sbr_cmp_s)-1:0] cmp_vec;
    sbr_pkg::sbr_cmp_s                    cmp;

    sbr_sync2 #(
        .W ($bits(sbr_pkg::sbr_cmp_s))
    ) u_sync (
        .clk_in  (clk_in),
        .nrst_in (nrst_in),
        .d_in    (cmp_in),
        .q_out   (cmp_vec)
    );

    assign cmp = sbr_pkg::sbr_cmp_s'(cmp_vec);

    // --------------------
    // Declarations
    // --------------------
    sbr_pkg::sbr_state_e state_r;
    sbr_pkg::sbr_state_e state_nxt;
    logic [LW-1:0]       leb_cnt_r;
    logic                gate_d_r;
    logic                gate_rise;
    logic                blank;
    logic                burst_gate;
    logic                switching;
    logic                peak_hit;
    logic                burst_hit;
    logic                pwm_hit;
    logic [CW-1:0]       burst_cnt_r;
    logic [CW-1:0]       ovl_cnt_r;
    logic [CW-1:0]       spike_cnt_r;
    logic [CW-1:0]       arm_cnt_r;
    logic                burst_due;
    logic                ovl_due;
    logic                spike_due;
    logic                armed;
    logic                fast_fault;
    logic [1:0]          ctrl_r;
    logic                ack_r;
    logic [31:0]         rdata_r;
    logic [31:0]         status;

    // --------------------
    // Leading-edge blanking
    // --------------------
    assign gate_rise = cmp.gate_on & ~gate_d_r;
    assign blank     = gate_rise | (leb_cnt_r != '0);
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            gate_d_r  <= 1'b0;
            leb_cnt_r <= '0;
        end else begin
            gate_d_r <= cmp.gate_on;
            if (gate_rise) begin
                leb_cnt_r <= LW'(sbr_pkg::LEB_CYC);
            end else if (leb_cnt_r != '0) begin
                leb_cnt_r <= leb_cnt_r - LW'(1);
            end
        end
    end

    // --------------------
    // Current limiting
    // --------------------
    // Dynamic threshold: the lowered compare stands in for turn-off delay
    assign peak_hit  = ~blank & (cmp.slope_steep ? cmp.cs_peak_dyn
                                                  : cmp.cs_peak);
    assign burst_hit = ~blank & burst_gate & cmp.cs_burst;
    assign pwm_hit   = ~blank & cmp.cs_pwm;
    // Combinational so the pulse ends in the cycle the limit is seen
    assign pwm_latch_reset_out = ~switching | peak_hit | burst_hit
                               | pwm_hit;

    // --------------------
    // Blanking counters
    // --------------------
    assign burst_due = burst_cnt_r == CW'(BLANK_CYC);
    assign ovl_due   = ovl_cnt_r == CW'(BLANK_CYC);
    assign spike_due = spike_cnt_r == CW'(sbr_pkg::SPIKE_CYC);
    assign armed     = arm_cnt_r == CW'(ARM_CYC);

    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            burst_cnt_r <= '0;
        end else if (state_r != sbr_pkg::ST_NORMAL || !cmp.fb_low) begin
            burst_cnt_r <= '0;
        end else if (!burst_due) begin
            burst_cnt_r <= burst_cnt_r + CW'(1);
        end
    end
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            ovl_cnt_r <= '0;
        end else if (state_r != sbr_pkg::ST_NORMAL || !cmp.fb_over) begin
            ovl_cnt_r <= '0;
        end else if (!ovl_due) begin
            ovl_cnt_r <= ovl_cnt_r + CW'(1);
        end
    end
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            spike_cnt_r <= '0;
        end else if (state_r != sbr_pkg::ST_SPIKE) begin
            spike_cnt_r <= '0;
        end else if (!spike_due) begin
            spike_cnt_r <= spike_cnt_r + CW'(1);
        end
    end
    // Restarts from zero on every power-on of the controller
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            arm_cnt_r <= '0;
        end else if (state_r == sbr_pkg::ST_CHARGE) begin
            arm_cnt_r <= '0;
        end else if (!armed) begin
            arm_cnt_r <= arm_cnt_r + CW'(1);
        end
    end

    // --------------------
    // Protection and mode sequencer
    // --------------------
    assign fast_fault = cmp.vcc_ovp | cmp.over_temp | cmp.vcc_uv
                      | cmp.short_opto
                      | (cmp.ext_req & armed
                         & ctrl_r[sbr_pkg::CTRL_REQ]);

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            sbr_pkg::ST_NORMAL: begin
                if (fast_fault) begin
                    state_nxt = sbr_pkg::ST_RST_OFF;
                end else if (ovl_due) begin
                    state_nxt = ctrl_r[sbr_pkg::CTRL_EXT]
                              ? sbr_pkg::ST_EXTEND
                              : sbr_pkg::ST_SPIKE;
                end else if (burst_due && cmp.fb_low) begin
                    state_nxt = sbr_pkg::ST_BURST_OFF;
                end
            end
            sbr_pkg::ST_BURST_OFF: begin
                if (fast_fault) begin
                    state_nxt = sbr_pkg::ST_RST_OFF;
                end else if (cmp.fb_over) begin
                    state_nxt = sbr_pkg::ST_NORMAL;
                end else if (cmp.fb_wake) begin
                    state_nxt = sbr_pkg::ST_BURST_ON;
                end
            end
            sbr_pkg::ST_BURST_ON: begin
                if (fast_fault) begin
                    state_nxt = sbr_pkg::ST_RST_OFF;
                end else if (cmp.fb_over) begin
                    state_nxt = sbr_pkg::ST_NORMAL;
                end else if (cmp.fb_sleep) begin
                    state_nxt = sbr_pkg::ST_BURST_OFF;
                end
            end
            sbr_pkg::ST_EXTEND: begin
                if (fast_fault) begin
                    state_nxt = sbr_pkg::ST_RST_OFF;
                end else if (!cmp.fb_over) begin
                    state_nxt = sbr_pkg::ST_NORMAL;
                end else if (cmp.extend_done) begin
                    state_nxt = sbr_pkg::ST_SPIKE;
                end
            end
            sbr_pkg::ST_SPIKE: begin
                if (fast_fault) begin
                    state_nxt = sbr_pkg::ST_RST_OFF;
                end else if (!cmp.fb_over) begin
                    state_nxt = sbr_pkg::ST_NORMAL;
                end else if (spike_due) begin
                    state_nxt = sbr_pkg::ST_RST_OFF;
                end
            end
            sbr_pkg::ST_RST_OFF: begin
                if (cmp.vcc_uv) begin
                    state_nxt = sbr_pkg::ST_CHARGE;
                end
            end
            sbr_pkg::ST_CHARGE: begin
                if (cmp.vcc_on) begin
                    state_nxt = sbr_pkg::ST_SOFT;
                end
            end
            sbr_pkg::ST_SOFT: begin
                if (fast_fault) begin
                    state_nxt = sbr_pkg::ST_RST_OFF;
                end else if (cmp.startup_done) begin
                    state_nxt = cmp.fb_over ? sbr_pkg::ST_RST_OFF
                                            : sbr_pkg::ST_NORMAL;
                end
            end
            default: begin
                state_nxt = sbr_pkg::ST_RST_OFF;
            end
        endcase
    end

    // Undervoltage reset lands in the startup phase
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            state_r <= sbr_pkg::ST_SOFT;
        end else begin
            state_r <= state_nxt;
        end
    end

    // --------------------
    // Mode outputs
    // --------------------
    assign burst_gate = (state_r == sbr_pkg::ST_BURST_OFF)
                      | (state_r == sbr_pkg::ST_BURST_ON);
    assign switching  = (state_r == sbr_pkg::ST_NORMAL)
                      | (state_r == sbr_pkg::ST_BURST_ON)
                      | (state_r == sbr_pkg::ST_EXTEND)
                      | (state_r == sbr_pkg::ST_SPIKE)
                      | (state_r == sbr_pkg::ST_SOFT);
    assign bias_en_out         = switching;
    assign burst_flag_out      = burst_gate;
    // Only the charge phase enables the cell, so never in burst
    assign startup_cell_en_out = state_r == sbr_pkg::ST_CHARGE;
    assign extend_clamp_out    = (state_r != sbr_pkg::ST_EXTEND)
                               & (state_r != sbr_pkg::ST_SPIKE);
    assign auto_restart_out    = (state_r == sbr_pkg::ST_RST_OFF)
                               | (state_r == sbr_pkg::ST_CHARGE);
    assign soft_start_out      = state_r == sbr_pkg::ST_SOFT;

    // --------------------
    // Register bus
    // --------------------
    always_comb begin
        status = '0;
        status[sbr_pkg::STAT_STATE +: 8] = state_r;
        status[sbr_pkg::STAT_BURST]      = burst_gate;
        status[sbr_pkg::STAT_BIAS]       = switching;
        status[sbr_pkg::STAT_CELL]       = startup_cell_en_out;
        status[sbr_pkg::STAT_CLAMP]      = ~extend_clamp_out;
        status[sbr_pkg::STAT_ARMED]      = armed;
        status[sbr_pkg::STAT_RST]        = auto_restart_out;
    end
    // One wait cycle per access; the request is taken on the second edge
    assign avs_waitrequest_out = (avs_read_in | avs_write_in) & ~ack_r;
    assign avs_readdata_out    = rdata_r;
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= (avs_read_in | avs_write_in) & ~ack_r;
        end
    end
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            rdata_r <= '0;
        end else if (avs_read_in && !ack_r) begin
            case (avs_address_in)
                sbr_pkg::ADDR_CTRL: rdata_r <= {30'h0, ctrl_r};
                sbr_pkg::ADDR_STAT: rdata_r <= status;
                default:            rdata_r <= '0;
            endcase
        end
    end
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            ctrl_r <= sbr_pkg::CTRL_RST;
        end else if (avs_write_in && ack_r && avs_byteenable_in[0]
                     && avs_address_in == sbr_pkg::ADDR_CTRL) begin
            ctrl_r <= avs_writedata_in[1:0];
        end
    end

endmodule

/* core/sbr_pkg.sv */
// Purpose: Shared constants and types of the burst/restart controller
// Assumes: 10 MHz core clock
// Notes:   Long counts are overridable at the top module

package sbr_pkg;

    // --------------------
    // Clock and timing
    // --------------------
    localparam int CLK_NS    = 100;
    localparam int LEB_NS    = 220;
    localparam int BLANK_MS  = 20;
    localparam int SPIKE_US  = 30;
    localparam int ARM_MS    = 1;
    // Least times, rounded up to whole cycles
    localparam int LEB_CYC   = (LEB_NS + CLK_NS - 1) / CLK_NS;
    localparam int BLANK_CYC = (BLANK_MS * 1000000 + CLK_NS - 1) / CLK_NS;
    localparam int SPIKE_CYC = (SPIKE_US * 1000 + CLK_NS - 1) / CLK_NS;
    localparam int ARM_CYC   = (ARM_MS * 1000000 + CLK_NS - 1) / CLK_NS;
    localparam int CNT_W     = 18;
    localparam int LEB_W     = 2;

    // --------------------
    // Register map (byte addresses)
    // --------------------
    localparam int          ADDR_W     = 4;
    localparam logic [3:0]  ADDR_CTRL  = 4'h0;
    localparam logic [3:0]  ADDR_STAT  = 4'h4;
    localparam int          CTRL_EXT   = 0;
    localparam int          CTRL_REQ   = 1;
    localparam logic [1:0]  CTRL_RST   = 2'h3;
    localparam int          STAT_STATE = 0;
    localparam int          STAT_BURST = 8;
    localparam int          STAT_BIAS  = 9;
    localparam int          STAT_CELL  = 10;
    localparam int          STAT_CLAMP = 11;
    localparam int          STAT_ARMED = 12;
    localparam int          STAT_RST   = 13;

    // --------------------
    // Types
    // --------------------
    typedef enum logic [7:0] {
        ST_NORMAL    = 8'h01,
        ST_BURST_OFF = 8'h02,
        ST_BURST_ON  = 8'h04,
        ST_EXTEND    = 8'h08,
        ST_SPIKE     = 8'h10,
        ST_RST_OFF   = 8'h20,
        ST_CHARGE    = 8'h40,
        ST_SOFT      = 8'h80
    } sbr_state_e;

    // Comparator decisions, all active high
    typedef struct packed {
        logic gate_on;
        logic cs_peak;
        logic cs_peak_dyn;
        logic slope_steep;
        logic cs_burst;
        logic cs_pwm;
        logic fb_low;
        logic fb_wake;
        logic fb_sleep;
        logic fb_over;
        logic extend_done;
        logic ext_req;
        logic vcc_ovp;
        logic over_temp;
        logic vcc_uv;
        logic vcc_on;
        logic short_opto;
        logic startup_done;
    } sbr_cmp_s;

endpackage

/* test/sbr_stage_model.sv */
// Purpose: Flyback stage and feedback network seen through comparators
// Assumes: Levels in millivolts; supply sags only while the core is off
// Notes:   Startup cell charges one step a cycle, no analog delay
`timescale 1ns/100ps
module sbr_stage_model #(
    parameter logic [15:0] VON_MV = 16'h4650
) (
    // Clock and reset
    input  wire logic        clk_in,
    input  wire logic        nrst_in,
    // Core pins and feedback level
    input  wire logic [15:0] fb_mv_in,
    input  wire logic        bias_en_in,
    input  wire logic        burst_flag_in,
    input  wire logic        cell_en_in,
    // Comparator levels
    output logic      [3:0]  fb_cmp_out,
    output logic      [1:0]  vcc_cmp_out
);
    // ------------------------------------------------------------
    // Supply and feedback
    // ------------------------------------------------------------
    logic [15:0] vcc_r;
    // Burst keeps the supply up, as the application must ensure
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            vcc_r <= 16'h3a98;
        end else if (cell_en_in) begin
            vcc_r <= vcc_r + 16'h0064;
        end else if (!bias_en_in && !burst_flag_in) begin
            vcc_r <= vcc_r - 16'h0064;
        end
    end
    assign fb_cmp_out = {fb_mv_in < 16'h0546, fb_mv_in > 16'h0dac,
                         fb_mv_in <= 16'h0bb8, fb_mv_in > 16'h0fa0};
    assign vcc_cmp_out = {vcc_r <= 16'h2904, vcc_r >= VON_MV};
endmodule

/* test/sbr_ctrl_chk.sv */
// Purpose: Assertions on the burst/restart controller pins
// Assumes: Comparator levels pass a two-cycle synchroniser
// Notes:   Counters mirror the sync so counts line up with the core
`timescale 1ns/100ps
module sbr_ctrl_chk #(
    parameter int BLANK_CYC = sbr_pkg::BLANK_CYC
) (
    // Clock and reset
    input wire logic              clk_in,
    input wire logic              nrst_in,
    // Watched pins
    input wire sbr_pkg::sbr_cmp_s cmp_in,
    input wire logic              pwm_latch_reset_out,
    input wire logic              bias_en_out,
    input wire logic              startup_cell_en_out,
    input wire logic              burst_flag_out,
    input wire logic              extend_clamp_out,
    input wire logic              auto_restart_out
);
    // ------------------------------------------------------------
    // Helpers and assertions
    // ------------------------------------------------------------
    logic [1:0] lo_r;
    logic [1:0] ov_r;
    int         lo_cnt_r;
    int         ov_cnt_r;
    logic       fast_w;
    assign fast_w = cmp_in.vcc_ovp | cmp_in.over_temp | cmp_in.short_opto;
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            lo_r     <= 2'h0;
            ov_r     <= 2'h0;
            lo_cnt_r <= 0;
            ov_cnt_r <= 0;
        end else begin
            lo_r     <= {lo_r[0], cmp_in.fb_low};
            ov_r     <= {ov_r[0], cmp_in.fb_over};
            lo_cnt_r <= lo_r[1] ? lo_cnt_r + 1 : 0;
            ov_cnt_r <= ov_r[1] ? ov_cnt_r + 1 : 0;
        end
    end
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!nrst_in);
    property p_cell; burst_flag_out |-> !startup_cell_en_out; endproperty
    a_cell: assert property (p_cell)
        else $error("startup cell on in burst");
    property p_exit; cmp_in.fb_over[*3] ##0 burst_flag_out
        |-> ##[0:2] !burst_flag_out; endproperty
    a_exit: assert property (p_exit)
        else $error("burst kept above overload level");
    property p_blank; $rose(cmp_in.gate_on) && bias_en_out
        |-> ##2 (!pwm_latch_reset_out || !bias_en_out)[*4]; endproperty
    a_blank: assert property (p_blank)
        else $error("sense not blanked after switch-on");
    property p_peak; (cmp_in.gate_on && cmp_in.cs_peak
        && !cmp_in.slope_steep)[*8] |-> pwm_latch_reset_out; endproperty
    a_peak: assert property (p_peak)
        else $error("peak limit did not end pulse");
    property p_slope; (cmp_in.gate_on && cmp_in.cs_peak_dyn
        && cmp_in.slope_steep)[*8] |-> pwm_latch_reset_out; endproperty
    a_slope: assert property (p_slope)
        else $error("steep ramp limit did not end pulse");
    property p_entry; $rose(burst_flag_out) |-> lo_cnt_r >= BLANK_CYC;
    endproperty
    a_entry: assert property (p_entry)
        else $error("burst entered before blanking time");
    property p_clamp; $fell(extend_clamp_out) && !auto_restart_out
        |-> ov_cnt_r >= BLANK_CYC; endproperty
    a_clamp: assert property (p_clamp)
        else $error("clamp released before blanking time");
    property p_fast; fast_w[*3] ##0 !startup_cell_en_out
        |-> ##[0:2] (auto_restart_out || startup_cell_en_out); endproperty
    a_fast: assert property (p_fast)
        else $error("fast fault did not restart");
endmodule
bind sbr_ctrl sbr_ctrl_chk #(.BLANK_CYC(BLANK_CYC)) u_chk (
    .clk_in(clk_in), .nrst_in(nrst_in), .cmp_in(cmp_in),
    .pwm_latch_reset_out(pwm_latch_reset_out), .bias_en_out(bias_en_out),
    .startup_cell_en_out(startup_cell_en_out),
    .burst_flag_out(burst_flag_out), .extend_clamp_out(extend_clamp_out),
    .auto_restart_out(auto_restart_out));

/* test/sbr_ctrl_bench.sv */
// Purpose: Self-checking bench of the burst/restart controller
// Assumes: Counts shortened through the top parameters
// Notes:   Pin bits: pwm bias cell burst clamp restart soft
`timescale 1ns/100ps
module sbr_ctrl_bench;
    // ------------------------------------------------------------
    // Signals and helpers
    // ------------------------------------------------------------
    logic              clk_in  = 1'b0;
    logic              nrst_in = 1'b0;
    sbr_pkg::sbr_cmp_s cmp     = '0;
    sbr_pkg::sbr_cmp_s cmp_w;
    logic [3:0]        adr     = 4'h0;
    logic              rd      = 1'b0;
    logic              wr      = 1'b0;
    logic [31:0]       wdat    = 32'h0;
    logic [31:0]       rdat;
    logic              wait_w;
    logic [15:0]       fb      = 16'h07d0;
    logic [3:0]        fbc;
    logic [1:0]        vcc;
    wire logic [6:0]   outs;
    logic [31:0]       q;
    int                errors  = 0;
    int                checks  = 0;
    initial forever #50 clk_in = ~clk_in;
    always_comb begin
        cmp_w = cmp;
        {cmp_w.fb_low, cmp_w.fb_wake, cmp_w.fb_sleep, cmp_w.fb_over} = fbc;
        {cmp_w.vcc_uv, cmp_w.vcc_on} = vcc;
    end
    sbr_ctrl #(.BLANK_CYC(50), .ARM_CYC(20)) dut (
        .clk_in(clk_in), .nrst_in(nrst_in), .cmp_in(cmp_w),
        .avs_address_in(adr), .avs_read_in(rd), .avs_write_in(wr),
        .avs_writedata_in(wdat), .avs_byteenable_in(4'hf),
        .avs_readdata_out(rdat), .avs_waitrequest_out(wait_w),
        .pwm_latch_reset_out(outs[6]), .bias_en_out(outs[5]),
        .startup_cell_en_out(outs[4]), .burst_flag_out(outs[3]),
        .extend_clamp_out(outs[2]), .auto_restart_out(outs[1]),
        .soft_start_out(outs[0]));
    sbr_stage_model stage (
        .clk_in(clk_in), .nrst_in(nrst_in), .fb_mv_in(fb),
        .bias_en_in(outs[5]), .burst_flag_in(outs[3]),
        .cell_en_in(outs[4]), .fb_cmp_out(fbc), .vcc_cmp_out(vcc));
    task automatic end_of_test();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_in);
    endtask
    task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk7(input logic [6:0] m, input logic [6:0] e);
        chk32({25'h0, outs & m}, {25'h0, e});
    endtask
    task automatic wait_bit(input int i);
        int n;
        n = 0;
        while (outs[i] !== 1'b1 && n < 400) begin
            @(posedge clk_in);
            n++;
        end
        if (n >= 400) begin
            errors++;
            end_of_test();
        end
    endtask
    // Holds the request until waitrequest is seen low at an edge
    task automatic bus(input logic w, input logic [3:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        adr <= a;
        wdat <= d;
        rd <= !w;
        wr <= w;
        do begin
            @(posedge clk_in);
            n++;
        end while (wait_w !== 1'b0 && n < 20);
        q = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
        if (n >= 20) begin
            errors++;
            end_of_test();
        end
        @(posedge clk_in);
    endtask
    task automatic do_reset();
        nrst_in <= 1'b0;
        cyc(6);
        nrst_in <= 1'b1;
        cyc(1);
    endtask
    task automatic to_normal();
        cmp.startup_done <= 1'b1;
        cyc(4);
        cmp.startup_done <= 1'b0;
        cyc(1);
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_regs();
        bus(1'b0, 4'h4, 32'h0);
        chk32(q, 32'h0000_0280);
        bus(1'b1, 4'h4, 32'hffff_ffff);
        bus(1'b0, 4'h0, 32'h0);
        chk32(q, 32'h0000_0003);
        bus(1'b0, 4'h8, 32'h0);
        chk32(q, 32'h0000_0000);
    endtask
    task automatic t_limit();
        cmp.gate_on <= 1'b1;
        cmp.cs_peak <= 1'b1;
        cyc(4);
        chk7(7'h40, 7'h00);
        cyc(4);
        chk7(7'h40, 7'h40);
        cmp.cs_peak <= 1'b0;
        cmp.slope_steep <= 1'b1;
        cmp.cs_peak_dyn <= 1'b1;
        cyc(4);
        chk7(7'h40, 7'h40);
        cmp.cs_peak_dyn <= 1'b0;
        cmp.cs_burst <= 1'b1;
        cyc(4);
        chk7(7'h40, 7'h00);
        cmp <= '0;
        cyc(3);
        cmp.gate_on <= 1'b1;
        cmp.cs_pwm <= 1'b1;
        cyc(4);
        chk7(7'h40, 7'h00);
        cyc(4);
        chk7(7'h40, 7'h40);
        cmp <= '0;
    endtask
    task automatic t_burst();
        fb <= 16'h03e8;
        cyc(30);
        chk7(7'h08, 7'h00);
        cyc(30);
        chk7(7'h78, 7'h48);
        fb <= 16'h0e10;
        cyc(5);
        chk7(7'h28, 7'h28);
        cmp.gate_on <= 1'b1;
        cyc(8);
        cmp.cs_burst <= 1'b1;
        cyc(4);
        chk7(7'h40, 7'h40);
        cmp.cs_burst <= 1'b0;
        fb <= 16'h0b54;
        cyc(5);
        chk7(7'h38, 7'h08);
        fb <= 16'h1004;
        cyc(5);
        chk7(7'h28, 7'h20);
        cmp.gate_on <= 1'b0;
    endtask
    // Both blanking modes; restart cycle follows the extended one
    task automatic t_over();
        for (int e = 0; e < 2; e++) begin
            fb <= 16'h07d0;
            do_reset();
            bus(1'b1, 4'h0, {30'h0, 1'b1, e[0]});
            to_normal();
            fb <= 16'h1004;
            cyc(40);
            chk7(7'h06, 7'h04);
            cyc(25);
            chk7(7'h06, 7'h00);
            if (e == 1) begin
                cyc(20);
                chk7(7'h02, 7'h00);
                cmp.extend_done <= 1'b1;
                cyc(20);
            end
            cyc(270);
            chk7(7'h02, 7'h00);
            cyc(30);
            chk7(7'h62, 7'h42);
        end
        wait_bit(4);
        chk7(7'h22, 7'h02);
        wait_bit(0);
        chk7(7'h10, 7'h00);
        to_normal();
        chk7(7'h02, 7'h02);
        fb <= 16'h07d0;
        cmp.extend_done <= 1'b0;
        wait_bit(0);
        to_normal();
        chk7(7'h23, 7'h20);
    endtask
    task automatic t_fast();
        do_reset();
        cmp.ext_req <= 1'b1;
        to_normal();
        chk7(7'h02, 7'h00);
        cyc(20);
        chk7(7'h02, 7'h02);
        cmp.ext_req <= 1'b0;
        for (int i = 0; i < 3; i++) begin
            do_reset();
            to_normal();
            {cmp.vcc_ovp, cmp.over_temp, cmp.short_opto} <= 3'b001 << i;
            cyc(4);
            chk7(7'h22, 7'h02);
            {cmp.vcc_ovp, cmp.over_temp, cmp.short_opto} <= 3'b000;
        end
    endtask
    initial begin
        do_reset();
        t_regs();
        to_normal();
        t_limit();
        t_burst();
        t_over();
        t_fast();
        end_of_test();
    end
endmodule
